/* File: hw/fss_pkg.sv */
`default_nettype none

package fss_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ************************************************************
  // Frequency table and parameter store
  // ************************************************************
  localparam int NUM_FREQ  = 33;
  localparam int IDX_W     = 6;
  localparam int NUM_QTY   = 3;
  localparam int NUM_PARAM = 14;
  localparam int NUM_WORDS = NUM_QTY * NUM_PARAM;
  localparam int PW        = 17;
  localparam int DECADE    = 12;

  localparam int P_FLOOR  = 0;
  localparam int P_CEIL   = 1;
  localparam int P_DENS   = 2;
  localparam int P_COUPLE = 3;

  localparam logic [PW-1:0] DEF_FLOOR  = 17'h00032;
  localparam logic [PW-1:0] DEF_CEIL   = 17'h04E20;
  localparam logic [PW-1:0] DEF_DENS   = 17'h1FFF4;
  localparam logic [PW-1:0] DEF_COUPLE = 17'h00000;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] ADDR_CMD     = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_FREQ    = 12'h008;
  localparam logic [11:0] ADDR_COUNT   = 12'h00C;
  localparam logic [11:0] ADDR_FREQ_HZ = 12'h010;
  localparam logic [11:0] ADDR_ACTIVE  = 12'h100;
  localparam logic [11:0] ADDR_USER    = 12'h200;

  localparam int CMD_SCAN_BIT    = 0;
  localparam int CMD_SINGLE_BIT  = 1;
  localparam int CMD_CLR_ERR_BIT = 2;
  localparam int ST_BOUNDS_BIT   = 0;
  localparam int ST_BADPAR_BIT   = 1;
  localparam int ST_BUSY_BIT     = 2;

  typedef enum logic [2:0] {
    FSS_IDLE   = 3'b000,
    FSS_CALC   = 3'b001,
    FSS_SETTLE = 3'b011,
    FSS_MEAS   = 3'b010,
    FSS_LOAD   = 3'b100
  } fss_state_type;

  function automatic logic [PW-1:0] fss_freq_hz(input int i);
    case (i)
      0: return 17'h00032;  1: return 17'h0003C;  2: return 17'h00046;
      3: return 17'h00050;  4: return 17'h00064;  5: return 17'h00078;
      6: return 17'h0008C;  7: return 17'h000A0;  8: return 17'h000C8;
      9: return 17'h000F0; 10: return 17'h0012C; 11: return 17'h00190;
     12: return 17'h001F4; 13: return 17'h00258; 14: return 17'h002BC;
     15: return 17'h00320; 16: return 17'h003E8; 17: return 17'h004B0;
     18: return 17'h00578; 19: return 17'h00640; 20: return 17'h007D0;
     21: return 17'h00960; 22: return 17'h00BB8; 23: return 17'h00FA0;
     24: return 17'h01388; 25: return 17'h01770; 26: return 17'h01B58;
     27: return 17'h01F40; 28: return 17'h02710; 29: return 17'h02EE0;
     30: return 17'h036B0; 31: return 17'h03E80; default: return 17'h04E20;
    endcase
  endfunction

  function automatic logic [PW-1:0] fss_factory(input int w);
    case (w)
      P_FLOOR:  return DEF_FLOOR;
      P_CEIL:   return DEF_CEIL;
      P_DENS:   return DEF_DENS;
      P_COUPLE: return DEF_COUPLE;
      default:  return '0;
    endcase
  endfunction

endpackage

`default_nettype wire

/* File: hw/fss_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

module fss_sequencer
  import fss_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  // Measurement engine
  output logic                  meas_start,
  input  wire logic             meas_done,
  output logic [IDX_W-1:0]      op_freq_idx,
  output logic [PW-1:0]         op_freq_hz,
  // Status and strap
  input  wire logic             user_defaults_set,
  output logic                  bounds_invalid_error,
  output logic                  busy
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    fss_state_type                  state;
    logic [NUM_WORDS-1:0][PW-1:0]   params;
    logic [NUM_WORDS-1:0][PW-1:0]   user;
    logic [IDX_W-1:0]               freq_idx;
    logic [PW-1:0]                  freq_hz;
    logic [15:0]                    scan_count;
    logic                           bounds_err;
    logic                           bad_param;
    logic [7:0]                     settle_cnt;
    logic                           is_scan;
    logic                           meas_start;
    logic [31:0]                    prdata;
    logic                           pslverr;
  } fss_regs_type;

  function automatic fss_regs_type fss_reset_value();
    fss_regs_type r;
    r = '0;
    r.state = FSS_LOAD;
    for (int w = 0; w < NUM_WORDS; w++) begin
      r.params[w] = fss_factory(w);
      r.user[w]   = fss_factory(w);
    end
    return r;
  endfunction

  localparam fss_regs_type RESET_VALUE = fss_reset_value();

  fss_regs_type st_reg;
  fss_regs_type st_next;

  // ************************************************************
  // Series arithmetic
  // ************************************************************
  logic [PW-1:0]    floor_hz;
  logic [PW-1:0]    ceil_hz;
  logic [PW-1:0]    dens;
  logic [PW-1:0]    dens_mag;
  logic             dens_pos;
  logic [IDX_W-1:0] lo_idx;
  logic [IDX_W-1:0] hi_idx;
  logic [IDX_W-1:0] up_idx;
  logic [IDX_W-1:0] dn_idx;
  logic [IDX_W-1:0] next_idx;
  logic             bounds_ok;
  int               step;

  function automatic logic dens_valid(input logic [PW-1:0] v);
    logic [PW-1:0] m;
    m = v[PW-1] ? PW'(-v) : v;
    return (m == 17'h00001) || (m == 17'h00002) || (m == 17'h00003) ||
           (m == 17'h00004) || (m == 17'h00006) || (m == 17'h0000C);
  endfunction

  assign floor_hz = st_reg.params[P_FLOOR];
  assign ceil_hz  = st_reg.params[P_CEIL];
  assign dens     = st_reg.params[P_DENS];
  assign dens_pos = !dens[PW-1];
  assign dens_mag = dens[PW-1] ? PW'(-dens) : dens;

  always_comb begin
    int  ph;
    logic have_lo;
    logic have_hi;
    logic have_up;
    logic pt;
    ph      = 0;
    have_lo = 1'b0;
    have_hi = 1'b0;
    have_up = 1'b0;
    pt      = 1'b0;
    lo_idx  = '0;
    hi_idx  = '0;
    up_idx  = '0;
    dn_idx  = '0;
    step    = DECADE / ((dens_mag == '0) ? 1 : int'(dens_mag));
    for (int i = 0; i < NUM_FREQ; i++) begin
      if (!have_lo && fss_freq_hz(i) >= floor_hz) begin
        lo_idx  = IDX_W'(i);
        have_lo = 1'b1;
        ph      = 0;
      end
      pt = have_lo && (ph == 0) && (fss_freq_hz(i) <= ceil_hz);
      if (pt) begin
        hi_idx  = IDX_W'(i);
        have_hi = 1'b1;
      end
      if (pt && (IDX_W'(i) > st_reg.freq_idx) && !have_up) begin
        up_idx  = IDX_W'(i);
        have_up = 1'b1;
      end
      if (pt && (IDX_W'(i) < st_reg.freq_idx)) begin
        dn_idx = IDX_W'(i);
      end
      if (have_lo) begin
        ph = (ph == step - 1) ? 0 : ph + 1;
      end
    end
    bounds_ok = have_hi && (floor_hz <= ceil_hz);
    // Same point set either way; sign only picks the walk
    if (dens_pos) begin
      if (st_reg.freq_idx < lo_idx || st_reg.freq_idx >= hi_idx) begin
        next_idx = lo_idx;
      end else begin
        next_idx = up_idx;
      end
    end else begin
      if (st_reg.freq_idx > hi_idx || st_reg.freq_idx <= lo_idx) begin
        next_idx = hi_idx;
      end else begin
        next_idx = dn_idx;
      end
    end
  end

  // ************************************************************
  // Bus decode and sequencing
  // ************************************************************
  logic        setup_ph;
  logic        access_ph;
  logic        wr_acc;
  logic [11:0] word_off;
  logic        hit_active;
  logic        hit_user;
  logic [5:0]  widx;

  assign setup_ph   = psel && !penable;
  assign access_ph  = psel && penable;
  assign wr_acc     = access_ph && pwrite;
  assign hit_active = (paddr >= ADDR_ACTIVE) && (paddr < ADDR_ACTIVE + 12'(NUM_WORDS * 4));
  assign hit_user   = (paddr >= ADDR_USER) && (paddr < ADDR_USER + 12'(NUM_WORDS * 4));
  assign word_off   = hit_user ? (paddr - ADDR_USER) : (paddr - ADDR_ACTIVE);
  assign widx       = word_off[7:2];

  always_comb begin
    logic idle;
    logic bad;
    idle    = (st_reg.state == FSS_IDLE);
    bad     = 1'b0;
    st_next = st_reg;
    st_next.meas_start = 1'b0;
    st_next.freq_hz    = fss_freq_hz(int'(st_reg.freq_idx));

    // Answer is staged in the setup cycle so read data comes from a flop
    if (setup_ph) begin
      st_next.prdata = '0;
      if (paddr[1:0] != 2'b00) begin
        bad = 1'b1;
      end else if (paddr == ADDR_CMD) begin
        bad = pwrite && !idle;
      end else if (paddr == ADDR_STATUS) begin
        st_next.prdata[ST_BOUNDS_BIT] = st_reg.bounds_err;
        st_next.prdata[ST_BADPAR_BIT] = st_reg.bad_param;
        st_next.prdata[ST_BUSY_BIT]   = !idle;
      end else if (paddr == ADDR_FREQ) begin
        st_next.prdata[IDX_W-1:0] = st_reg.freq_idx;
        bad = pwrite && (!idle || pwdata[IDX_W-1:0] >= IDX_W'(NUM_FREQ));
      end else if (paddr == ADDR_COUNT) begin
        st_next.prdata[15:0] = st_reg.scan_count;
      end else if (paddr == ADDR_FREQ_HZ) begin
        st_next.prdata[PW-1:0] = st_reg.freq_hz;
        bad = pwrite;
      end else if (hit_active) begin
        st_next.prdata[PW-1:0] = st_reg.params[widx];
        bad = pwrite && ((widx == 6'(P_DENS) && !dens_valid(pwdata[PW-1:0])) || !idle);
      end else if (hit_user) begin
        st_next.prdata[PW-1:0] = st_reg.user[widx];
        bad = pwrite && widx == 6'(P_DENS) && !dens_valid(pwdata[PW-1:0]);
      end else begin
        bad = 1'b1;
      end
      st_next.pslverr = bad;
    end

    if (wr_acc && !st_reg.pslverr) begin
      if (paddr == ADDR_CMD && pwdata[CMD_CLR_ERR_BIT]) begin
        st_next.bounds_err = 1'b0;
        st_next.bad_param  = 1'b0;
      end
      if (paddr == ADDR_FREQ) begin
        st_next.freq_idx = pwdata[IDX_W-1:0];
      end
      if (paddr == ADDR_COUNT) begin
        st_next.scan_count = pwdata[15:0];
      end
      if (hit_active) begin
        st_next.params[widx] = pwdata[PW-1:0];
      end
      if (hit_user) begin
        st_next.user[widx] = pwdata[PW-1:0];
      end
    end
    if (wr_acc && st_reg.pslverr && (hit_active || hit_user) && widx == 6'(P_DENS)) begin
      st_next.bad_param = 1'b1;
    end

    unique case (st_reg.state)
      FSS_LOAD: begin
        for (int w = 0; w < NUM_WORDS; w++) begin
          st_next.params[w] = user_defaults_set ? st_reg.user[w] : fss_factory(w);
        end
        st_next.state = FSS_IDLE;
      end
      FSS_IDLE: begin
        if (wr_acc && !st_reg.pslverr && paddr == ADDR_CMD) begin
          st_next.settle_cnt = 8'(SETTLE_CYCLES - 1);
          if (pwdata[CMD_SCAN_BIT]) begin
            st_next.is_scan = 1'b1;
            // Uncoupled scan measures at the present frequency
            st_next.state = (st_reg.params[P_COUPLE][1:0] != 2'b00) ? FSS_CALC
                                                                    : FSS_SETTLE;
          end else if (pwdata[CMD_SINGLE_BIT]) begin
            st_next.is_scan = 1'b0;
            st_next.state   = FSS_SETTLE;
          end
        end
      end
      FSS_CALC: begin
        if (bounds_ok) begin
          st_next.freq_idx = next_idx;
          st_next.state    = FSS_SETTLE;
        end else begin
          st_next.bounds_err = 1'b1;
          st_next.state      = FSS_IDLE;
        end
      end
      FSS_SETTLE: begin
        if (st_reg.settle_cnt == '0) begin
          st_next.meas_start = 1'b1;
          st_next.state      = FSS_MEAS;
        end else begin
          st_next.settle_cnt = st_reg.settle_cnt - 8'h01;
        end
      end
      FSS_MEAS: begin
        if (meas_done && !st_reg.meas_start) begin
          if (st_reg.is_scan) begin
            st_next.scan_count = st_reg.scan_count + 16'h0001;
          end
          st_next.state = FSS_IDLE;
        end
      end
      default: begin
        st_next.state = FSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= RESET_VALUE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready               = 1'b1;
  assign prdata               = st_reg.prdata;
  assign pslverr              = st_reg.pslverr && access_ph;
  assign meas_start           = st_reg.meas_start;
  assign op_freq_idx          = st_reg.freq_idx;
  assign op_freq_hz           = st_reg.freq_hz;
  assign bounds_invalid_error = st_reg.bounds_err;
  assign busy                 = (st_reg.state != FSS_IDLE);

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_calc_ok;
    st_reg.state == FSS_CALC && bounds_ok;
  endsequence

  sequence s_settled;
    st_reg.state == FSS_SETTLE && st_reg.settle_cnt == '0;
  endsequence

  a_start_after_settle: assert property (s_settled |=> meas_start ##1 !meas_start)
    else $error("measurement start not one pulse after settling");
  a_start_cause: assert property (meas_start |-> $past(st_reg.state) == FSS_SETTLE)
    else $error("measurement started without settling");
  a_bounds_flag: assert property (st_reg.state == FSS_CALC && !bounds_ok |=> bounds_invalid_error)
    else $error("bounds error not raised");
  a_step_in_series: assert property (s_calc_ok |=> op_freq_idx >= $past(lo_idx)
                                     && op_freq_idx <= $past(hi_idx))
    else $error("stepped outside series");
  a_wrap_up: assert property (s_calc_ok ##0 (dens_pos && op_freq_idx >= hi_idx)
                              |=> op_freq_idx == $past(lo_idx))
    else $error("ascending wrap not to lowest point");
  a_ascend_next: assert property (s_calc_ok ##0 (dens_pos && op_freq_idx >= lo_idx
                                  && op_freq_idx < hi_idx)
                                  |=> op_freq_idx > $past(op_freq_idx))
    else $error("ascending step did not rise");
  a_descend_next: assert property (s_calc_ok ##0 (!dens_pos && op_freq_idx > lo_idx
                                   && op_freq_idx <= hi_idx)
                                   |=> op_freq_idx < $past(op_freq_idx))
    else $error("descending step did not fall");
  a_single_count: assert property (st_reg.state == FSS_MEAS && !st_reg.is_scan
                                   && !wr_acc |=> $stable(st_reg.scan_count))
    else $error("single measurement changed scan count");
  a_uncoupled_hold: assert property (st_reg.state == FSS_IDLE && wr_acc && !st_reg.pslverr
                                     && paddr == ADDR_CMD && pwdata[CMD_SCAN_BIT]
                                     && st_reg.params[P_COUPLE][1:0] == 2'b00
                                     |=> st_reg.state == FSS_SETTLE && $stable(op_freq_idx))
    else $error("uncoupled scan moved frequency");

endmodule // fss_sequencer

`default_nettype wire

/* File: tb/fss_meas_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Measurement engine stand-in
// ************************************************************
// Delay 0 answers two cycles after the start pulse; larger values stall.
module fss_meas_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Handshake
  input  wire logic       meas_start,
  input  wire logic [7:0] meas_delay,
  output logic            meas_done
);
  logic       run_reg;
  logic [7:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg   <= 1'b0;
      cnt_reg   <= 8'h00;
      meas_done <= 1'b0;
    end else if (meas_start) begin
      run_reg   <= 1'b1;
      cnt_reg   <= meas_delay;
      meas_done <= 1'b0;
    end else if (run_reg && cnt_reg == 8'h00) begin
      run_reg   <= 1'b0;
      meas_done <= 1'b1;
    end else begin
      meas_done <= 1'b0;
      if (run_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule // fss_meas_model

`default_nettype wire

/* File: tb/fss_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module fss_sequencer_tb_top import fss_pkg::*; ;
  logic             pclk, presetn, psel, penable, pwrite, user_defaults_set;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd, cnt0;
  logic             pready, pslverr, meas_start, meas_done, bounds_invalid_error, busy;
  logic             err, got_start;
  logic [IDX_W-1:0] op_freq_idx, idx_s;
  logic [PW-1:0]    op_freq_hz, hz_s;
  logic [7:0]       meas_delay;
  int               errors, samples_checked, cycles;

  // ************************************************************
  // Cases: floor, ceiling, density, start index, index, Hz, bounds error
  // ************************************************************
  int rows [21][7] = '{
    '{150, 20000, 2, 0, 7, 160, 0},
    '{150, 20000, 2, 7, 13, 600, 0},
    '{150, 20000, 2, 31, 7, 160, 0},
    '{150, 20000, 2, 32, 7, 160, 0},
    '{150, 20000, -2, 0, 31, 16000, 0},
    '{150, 20000, -2, 7, 31, 16000, 0},
    '{150, 20000, -2, 20, 19, 1600, 0},
    '{150, 20000, -2, 32, 31, 16000, 0},
    '{100, 1000, 12, 10, 11, 400, 0},
    '{100, 1000, -12, 4, 16, 1000, 0},
    '{100, 1000, -12, 16, 15, 800, 0},
    '{50, 20000, 1, 24, 0, 50, 0},
    '{50, 20000, -1, 12, 0, 50, 0},
    '{50, 20000, 3, 5, 8, 200, 0},
    '{50, 20000, -3, 5, 4, 100, 0},
    '{50, 15000, 4, 30, 0, 50, 0},
    '{50, 15000, -4, 31, 30, 14000, 0},
    '{60, 900, 6, 2, 3, 80, 0},
    '{60, 900, -6, 1, 15, 800, 0},
    '{2000, 1000, 2, 5, 5, 120, 1},
    '{2100, 2200, -2, 5, 5, 120, 1}
  };
  logic [11:0] def_addr [7] = '{12'h100, 12'h104, 12'h108, 12'h10C, 12'h200, 12'h1A4, 12'h00C};
  logic [31:0] def_val  [7] = '{32'h32, 32'h4E20, 32'h1FFF4, 32'h0, 32'h32, 32'h0, 32'h0};

  fss_sequencer u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .meas_start(meas_start), .meas_done(meas_done), .op_freq_idx(op_freq_idx),
    .op_freq_hz(op_freq_hz), .user_defaults_set(user_defaults_set),
    .bounds_invalid_error(bounds_invalid_error), .busy(busy));

  fss_meas_model u_meas (
    .pclk(pclk), .presetn(presetn), .meas_start(meas_start), .meas_delay(meas_delay),
    .meas_done(meas_done));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic conclude();
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under this
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Captures the frequency seen with the start pulse, returns once idle
  task automatic wait_done();
    got_start = 1'b0;
    repeat (1000) begin
      @(negedge pclk);
      if (meas_start === 1'b1) begin
        got_start = 1'b1;
        idx_s = op_freq_idx;
        hz_s = op_freq_hz;
      end
      if (busy === 1'b0) break;
    end
    chk("idle after run", busy, 1'b0);
  endtask

  task automatic run_cmd(input logic [31:0] c);
    apb(1'b1, ADDR_CMD, c);
    wait_done();
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; user_defaults_set = 1'b0; meas_delay = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 21; i++) begin
      meas_delay <= (i % 2) ? 8'd40 : 8'd0;
      apb(1'b1, ADDR_ACTIVE, rows[i][0]);
      apb(1'b1, ADDR_ACTIVE + 12'h004, rows[i][1]);
      apb(1'b1, ADDR_ACTIVE + 12'h008, {15'h0, 17'(rows[i][2])});
      apb(1'b1, ADDR_ACTIVE + 12'h00C, 1 + i % 3);
      apb(1'b1, ADDR_FREQ, rows[i][3]);
      apb(1'b0, ADDR_COUNT, 32'h0);
      cnt0 = rd;
      run_cmd(32'h1);
      chk("start", got_start, !rows[i][6]);
      if (rows[i][6] == 0) begin
        chk("idx at start", idx_s, rows[i][4]);
        chk("hz at start", hz_s, rows[i][5]);
      end
      chk("bounds", bounds_invalid_error, rows[i][6]);
      apb(1'b0, ADDR_FREQ, 32'h0);
      chk("freq", rd, rows[i][4]);
      apb(1'b0, ADDR_COUNT, 32'h0);
      chk("count", rd, cnt0 + 1 - rows[i][6]);
      apb(1'b1, ADDR_CMD, 32'h4);
    end
    // ************************************************************
    // Uncoupled scan, refused command, single shot
    // ************************************************************
    apb(1'b1, ADDR_ACTIVE + 12'h00C, 32'h0);
    apb(1'b1, ADDR_FREQ, 32'h5);
    apb(1'b0, ADDR_COUNT, 32'h0);
    cnt0 = rd;
    apb(1'b1, ADDR_CMD, 32'h1);
    apb(1'b1, ADDR_CMD, 32'h1);
    chk("cmd busy", err, 1'b1);
    wait_done();
    chk("uncoupled start", got_start, 1'b1);
    chk("uncoupled idx", idx_s, 32'h5);
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk("uncoupled count", rd, cnt0 + 1);
    apb(1'b1, ADDR_ACTIVE + 12'h00C, 32'h1);
    run_cmd(32'h2);
    chk("single start", got_start, 1'b1);
    chk("single idx", idx_s, 32'h5);
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk("single count", rd, cnt0 + 1);
    apb(1'b1, ADDR_COUNT, 32'h7);
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk("count write", rd, 32'h7);
    // ************************************************************
    // Refused writes and map edges
    // ************************************************************
    foreach (def_val[k]) begin
      if (k < 2) begin
        apb(1'b1, ADDR_ACTIVE + 12'h008, k * 5);
        chk("bad density", err, 1'b1);
      end
    end
    apb(1'b1, ADDR_USER + 12'h008, 32'h5);
    chk("bad user density", err, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("bad param flag", rd[ST_BADPAR_BIT], 1'b1);
    apb(1'b0, ADDR_ACTIVE + 12'h008, 32'h0);
    chk("density kept", rd, 32'h1FFFE);
    apb(1'b1, ADDR_CMD, 32'h4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status clear", rd, 32'h0);
    apb(1'b1, 12'h1A4, 32'h1234);
    apb(1'b0, 12'h1A4, 32'h0);
    chk("last word", rd, 32'h1234);
    apb(1'b0, 12'h1A8, 32'h0);
    chk("past store", err, 1'b1);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", err, 1'b1);
    apb(1'b1, ADDR_FREQ_HZ, 32'h32);
    chk("hz read only", err, 1'b1);
    apb(1'b1, ADDR_FREQ, 32'd33);
    chk("idx 33", err, 1'b1);
    apb(1'b0, ADDR_FREQ_HZ, 32'h0);
    chk("hz of idx", rd, 32'd120);
    // ************************************************************
    // Second reset with the strap high
    // ************************************************************
    user_defaults_set <= 1'b1;
    presetn <= 1'b0;
    @(negedge pclk);
    chk("busy in reset", busy, 1'b1);
    chk("start in reset", meas_start, 1'b0);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("hz after reset", op_freq_hz, 32'h32);
    chk("idle after reset", busy, 1'b0);
    foreach (def_addr[k]) begin
      apb(1'b0, def_addr[k], 32'h0);
      chk("default", rd, def_val[k]);
    end
    apb(1'b1, ADDR_ACTIVE + 12'h00C, 32'h1);
    run_cmd(32'h1);
    chk("default first idx", idx_s, 32'd32);
    chk("default first hz", hz_s, 32'h4E20);
    conclude();
  end
endmodule // fss_sequencer_tb_top

`default_nettype wire
